// >>> core/bim_cfg.svh
// Purpose: Offsets, field positions, masks and reset values of the block
// Assumes: 8-bit register bytes on a 16-bit byte address
// Notes: Macro list follows
`ifndef BIM_CFG_SVH
`define BIM_CFG_SVH

`define BIM_ADDR_W 16
`define BIM_OFF_ST_HIGH 16'h0112
`define BIM_OFF_ST_LOW 16'h0113
`define BIM_OFF_EN_HIGH 16'h0116
`define BIM_OFF_EN_LOW 16'h0117
`define BIM_OFF_MODE_LOW 16'h011b

`define BIM_MASK_HIGH 8'hde
`define BIM_MASK_LOW 8'h60
`define BIM_MASK_MODE 8'hf1
`define BIM_RST_BYTE 8'h00
`define BIM_READ_IDLE 8'h00

`define BIM_BIT_FRAMER 2
`define BIM_BIT_LINE_IF 1
`define BIM_BIT_SOH 6
`define BIM_BIT_VC3_POH 5
`define BIM_BIT_QUICK_LOCK_OFF 7
`define BIM_BIT_SDH_CHECK 6
`define BIM_BIT_MF_MARKER 5
`define BIM_BIT_TIMING_SRC 4
`define BIM_BIT_MAP_SEL 0

`endif

// >>> core/bim_pkg.sv
// Purpose: Shared types of the block interrupt and mode control
// Assumes: Constants live in bim_cfg.svh
// Notes: Types only
package bim_pkg;
  typedef logic [7:0] bim_byte_t;
  typedef logic [15:0] bim_addr_t;
  typedef enum {VAL_OFF, VAL_HUNT, VAL_LIVE} bim_val_state_t;
endpackage

// >>> core/bim_bus_if.sv
// Purpose: Carries decoded host accesses from the pin port to the registers
// Assumes: Single clock domain
// Notes: wr_stb is a one-cycle pulse, rd_act a level
interface bim_bus_if;
  logic wr_stb;
  logic rd_act;
  bim_pkg::bim_addr_t addr;
  bim_pkg::bim_byte_t wdata;
  modport src (output wr_stb, output rd_act, output addr, output wdata);
  modport dst (input wr_stb, input rd_act, input addr, input wdata);
endinterface

// >>> core/bim_host_port.sv
// Purpose: Synchronises the 8-bit host pins and forms access strobes
// Assumes: Host holds address and data stable around its strobes
// Notes: Write takes effect at the end of the write strobe
module bim_host_port (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire bim_pkg::bim_addr_t addr,
  input wire bim_pkg::bim_byte_t data_in,
  bim_bus_if.src bus
);
  logic [26:0] s1_reg, s1_next;
  logic [26:0] s2_reg, s2_next;
  logic [26:0] s3_reg, s3_next;
  logic wr_act2, wr_act3, rd_act3;

  // Two stages before any logic looks at pin levels
  always_comb begin
    s1_next = {cs_n, rd_n, wr_n, addr, data_in};
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_reg <= 27'h7ffffff;
      s2_reg <= 27'h7ffffff;
      s3_reg <= 27'h7ffffff;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign wr_act2 = !s2_reg[26] && !s2_reg[24];
  assign wr_act3 = !s3_reg[26] && !s3_reg[24];
  assign rd_act3 = !s3_reg[26] && !s3_reg[25];
  // Trailing edge so data has settled long before it is used
  assign bus.wr_stb = wr_act3 && !wr_act2;
  assign bus.rd_act = rd_act3;
  assign bus.addr = s3_reg[23:8];
  assign bus.wdata = s3_reg[7:0];
endmodule // bim_host_port

// >>> core/bim_marker.sv
// Purpose: Builds one frame marker line from start and V1 pulses
// Assumes: Pulses come from the bus timing logic on this clock
// Notes: One cycle of latency
module bim_marker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic frame_start,
  input wire logic v1_mark,
  input wire logic mf_en,
  input wire logic stm1_mode,
  output logic marker
);
  logic marker_reg, marker_next;

  always_comb begin
    // V1 pulse only in STS-3/STM-1 mode and only when enabled
    marker_next = frame_start || (v1_mark && mf_en && stm1_mode);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      marker_reg <= 1'b0;
    end else begin
      marker_reg <= marker_next;
    end
  end

  assign marker = marker_reg;
endmodule // bim_marker

// >>> core/bim_top.sv
// Purpose: Block interrupt enables, block status and mode control byte 0
// Assumes: Status inputs are already gated by source-level enables
// Notes: Registers reached only through the 8-bit host pins
`include "bim_cfg.svh"
module bim_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] blk_status_high,
  input wire logic [7:0] blk_status_low,
  output logic irq_n,
  output logic jitter_atten_quick_lock_off,
  output logic map_select,
  input wire logic sonet_mode,
  input wire logic stm1_mode,
  input wire logic sdh_struct_valid,
  input wire logic [7:0] drop_data_in,
  output logic [7:0] drop_data,
  output logic drop_data_oe,
  input wire logic drop_frame_start,
  input wire logic drop_v1_mark,
  output logic drop_frame_marker,
  input wire logic add_frame_start,
  input wire logic add_v1_mark,
  output logic add_frame_marker,
  output logic add_frame_marker_oe
);
  bim_bus_if bus ();

  bim_host_port u_host (
    .clock(clock),
    .rstn(rstn),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .addr(addr),
    .data_in(data_in),
    .bus(bus)
  );

  function automatic logic hit(input bim_pkg::bim_addr_t a, input bim_pkg::bim_addr_t off);
    hit = (a == off);
  endfunction

  // Shared decode keeps the write and read maps from drifting apart
  function automatic logic [4:0] reg_sel(input bim_pkg::bim_addr_t a);
    logic [4:0] s;
    s = 5'h00;
    s[0] = hit(a, `BIM_OFF_EN_HIGH);
    s[1] = hit(a, `BIM_OFF_EN_LOW);
    s[2] = hit(a, `BIM_OFF_MODE_LOW);
    s[3] = hit(a, `BIM_OFF_ST_HIGH);
    s[4] = hit(a, `BIM_OFF_ST_LOW);
    return s;
  endfunction

  logic [4:0] sel;

  assign sel = reg_sel(bus.addr);

  // Register group
  bim_pkg::bim_byte_t en_high_reg, en_high_next;
  bim_pkg::bim_byte_t en_low_reg, en_low_next;
  bim_pkg::bim_byte_t mode_reg, mode_next;

  always_comb begin
    en_high_next = en_high_reg;
    en_low_next = en_low_reg;
    mode_next = mode_reg;
    if (bus.wr_stb) begin
      // Unused bits never store a one
      if (sel[0]) begin
        en_high_next = bus.wdata & `BIM_MASK_HIGH;
      end
      if (sel[1]) begin
        en_low_next = bus.wdata & `BIM_MASK_LOW;
      end
      if (sel[2]) begin
        mode_next = bus.wdata & `BIM_MASK_MODE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      en_high_reg <= `BIM_RST_BYTE;
      en_low_reg <= `BIM_RST_BYTE;
      mode_reg <= `BIM_RST_BYTE;
    end else begin
      en_high_reg <= en_high_next;
      en_low_reg <= en_low_next;
      mode_reg <= mode_next;
    end
  end

  // Status and interrupt group
  bim_pkg::bim_byte_t st_high_reg, st_high_next;
  bim_pkg::bim_byte_t st_low_reg, st_low_next;
  logic irq_n_reg, irq_n_next;
  logic [15:0] pend;
  logic pend_high, pend_low;

  always_comb begin
    // Level view of pending work; clearing happens at the source
    st_high_next = blk_status_high & `BIM_MASK_HIGH;
    st_low_next = blk_status_low & `BIM_MASK_LOW;
  end

  // Per-bit gate of block status by its block enable
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gate
      assign pend[gi] = st_low_reg[gi] && en_low_reg[gi];
      assign pend[gi + 8] = st_high_reg[gi] && en_high_reg[gi];
    end
  endgenerate

  assign pend_high = |pend[15:8];
  assign pend_low = |pend[7:0];

  always_comb begin
    // Enable alone cannot fire: status must be pending too
    irq_n_next = !(pend_high || pend_low);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_high_reg <= `BIM_RST_BYTE;
      st_low_reg <= `BIM_RST_BYTE;
      irq_n_reg <= 1'b1;
    end else begin
      st_high_reg <= st_high_next;
      st_low_reg <= st_low_next;
      irq_n_reg <= irq_n_next;
    end
  end

  // Read group
  bim_pkg::bim_byte_t rdata_reg, rdata_next;
  logic rd_oe_reg, rd_oe_next;

  always_comb begin
    rdata_next = `BIM_READ_IDLE;
    rd_oe_next = bus.rd_act;
    if (bus.rd_act) begin
      if (sel[0]) begin
        rdata_next = en_high_reg;
      end else if (sel[1]) begin
        rdata_next = en_low_reg;
      end else if (sel[2]) begin
        rdata_next = mode_reg;
      end else if (sel[3]) begin
        rdata_next = st_high_reg;
      end else if (sel[4]) begin
        rdata_next = st_low_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_reg <= `BIM_READ_IDLE;
      rd_oe_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rd_oe_reg <= rd_oe_next;
    end
  end

  // Drop bus validation group
  bim_pkg::bim_val_state_t val_reg, val_next;
  bim_pkg::bim_byte_t drop_reg, drop_next;
  logic drop_oe_reg, drop_oe_next;
  logic sdh_check, quick_lock_off_bit, map_sel_bit;

  // Named views of mode byte 0 fields
  assign sdh_check = mode_reg[`BIM_BIT_SDH_CHECK];
  assign quick_lock_off_bit = mode_reg[`BIM_BIT_QUICK_LOCK_OFF];
  assign map_sel_bit = mode_reg[`BIM_BIT_MAP_SEL];

  always_comb begin
    val_next = val_reg;
    unique case (val_reg)
      bim_pkg::VAL_OFF: begin
        if (sdh_check) begin
          val_next = bim_pkg::VAL_HUNT;
        end
      end
      bim_pkg::VAL_HUNT: begin
        if (!sdh_check) begin
          val_next = bim_pkg::VAL_OFF;
        end else if (sdh_struct_valid) begin
          val_next = bim_pkg::VAL_LIVE;
        end
      end
      bim_pkg::VAL_LIVE: begin
        if (!sdh_check) begin
          val_next = bim_pkg::VAL_OFF;
        end else if (!sdh_struct_valid) begin
          // Loss of structure drops the bus rather than pass garbage
          val_next = bim_pkg::VAL_HUNT;
        end
      end
      default: begin
        // Stray code falls back to the safe, bus-off state
        val_next = bim_pkg::VAL_OFF;
      end
    endcase
  end

  always_comb begin
    // SONET mode does not look at the check bit
    drop_oe_next = sonet_mode || (val_next == bim_pkg::VAL_LIVE);
    if (drop_oe_next) begin
      drop_next = drop_data_in;
    end else begin
      // Disabled bus shows zero, never stale bytes
      drop_next = `BIM_READ_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      val_reg <= bim_pkg::VAL_OFF;
      drop_reg <= `BIM_READ_IDLE;
      drop_oe_reg <= 1'b0;
    end else begin
      val_reg <= val_next;
      drop_reg <= drop_next;
      drop_oe_reg <= drop_oe_next;
    end
  end

  // Frame marker group
  logic add_oe_reg, add_oe_next;

  bim_marker u_drop_marker (
    .clock(clock),
    .rstn(rstn),
    .frame_start(drop_frame_start),
    .v1_mark(drop_v1_mark),
    .mf_en(mode_reg[`BIM_BIT_MF_MARKER]),
    .stm1_mode(stm1_mode),
    .marker(drop_frame_marker)
  );

  bim_marker u_add_marker (
    .clock(clock),
    .rstn(rstn),
    .frame_start(add_frame_start),
    .v1_mark(add_v1_mark),
    .mf_en(mode_reg[`BIM_BIT_MF_MARKER]),
    .stm1_mode(stm1_mode),
    .marker(add_frame_marker)
  );

  always_comb begin
    // Add marker is driven only when this bus is the timing source
    add_oe_next = mode_next[`BIM_BIT_TIMING_SRC];
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      add_oe_reg <= 1'b0;
    end else begin
      add_oe_reg <= add_oe_next;
    end
  end

  assign data_out = rdata_reg;
  assign data_oe = rd_oe_reg;
  assign irq_n = irq_n_reg;
  // Recovery time suffers if software leaves this set
  assign jitter_atten_quick_lock_off = quick_lock_off_bit;
  assign map_select = map_sel_bit;
  assign drop_data = drop_reg;
  assign drop_data_oe = drop_oe_reg;
  assign add_frame_marker_oe = add_oe_reg;
endmodule // bim_top

// >>> verif/bim_checker.sv
// Purpose: Port assertions for bim_top
// Assumes: Host holds cs_n low 6 clocks past wr_n rise
// Notes: Bound after the module
module bim_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [7:0] blk_status_high,
  input wire logic [7:0] blk_status_low,
  input wire logic irq_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic jitter_atten_quick_lock_off,
  input wire logic add_frame_marker_oe,
  input wire logic sonet_mode,
  input wire logic stm1_mode,
  input wire logic sdh_struct_valid,
  input wire logic [7:0] drop_data,
  input wire logic drop_data_oe,
  input wire logic drop_frame_start,
  input wire logic drop_v1_mark,
  input wire logic drop_frame_marker,
  input wire logic add_frame_start,
  input wire logic add_frame_marker
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_irq_quiet;
    (!(|blk_status_high) && !(|blk_status_low)) [*3] |=> irq_n;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without status");
  property p_irq_cause;
    $fell(irq_n) |-> (|$past(blk_status_high, 2)) || (|$past(blk_status_low, 2));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq fell, no cause");
  // Writes need cs_n low, so a long idle must leave mode pins alone
  property p_mode_hold;
    cs_n [*8] |-> $stable(jitter_atten_quick_lock_off) && $stable(add_frame_marker_oe);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode pin moved");
  property p_drop_zero;
    !drop_data_oe |-> drop_data == 8'h00;
  endproperty
  a_drop_zero: assert property (p_drop_zero) else $error("drop data leaks");
  property p_drop_lost;
    (!sonet_mode && !sdh_struct_valid) [*2] |-> !drop_data_oe;
  endproperty
  a_drop_lost: assert property (p_drop_lost) else $error("drop bus on, no frame");
  property p_drop_start;
    drop_frame_start |=> drop_frame_marker;
  endproperty
  a_drop_start: assert property (p_drop_start) else $error("drop start lost");
  property p_drop_none;
    !drop_frame_start && (!drop_v1_mark || !stm1_mode) |=> !drop_frame_marker;
  endproperty
  a_drop_none: assert property (p_drop_none) else $error("stray drop marker");
  property p_add_start;
    add_frame_start |=> add_frame_marker;
  endproperty
  a_add_start: assert property (p_add_start) else $error("add start lost");
  property p_read_idle;
    rd_n [*6] |-> !data_oe && data_out == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read bus busy");
  c_irq: cover property (!irq_n);
  c_drop: cover property (drop_data_oe && !sonet_mode);
  c_mark: cover property (drop_frame_marker && !$past(drop_frame_start));
endmodule // bim_checker
bind bim_top bim_checker u_bim_checker (
  .clock(clock),
  .rstn(rstn),
  .cs_n(cs_n),
  .rd_n(rd_n),
  .blk_status_high(blk_status_high),
  .blk_status_low(blk_status_low),
  .irq_n(irq_n),
  .data_out(data_out),
  .data_oe(data_oe),
  .jitter_atten_quick_lock_off(jitter_atten_quick_lock_off),
  .add_frame_marker_oe(add_frame_marker_oe),
  .sonet_mode(sonet_mode),
  .stm1_mode(stm1_mode),
  .sdh_struct_valid(sdh_struct_valid),
  .drop_data(drop_data),
  .drop_data_oe(drop_data_oe),
  .drop_frame_start(drop_frame_start),
  .drop_v1_mark(drop_v1_mark),
  .drop_frame_marker(drop_frame_marker),
  .add_frame_start(add_frame_start),
  .add_frame_marker(add_frame_marker)
);

// >>> verif/tb_bim_top.sv
// Purpose: Self-checking bench for bim_top
// Assumes: Fixed waits follow the host port timing
// Notes: Seed 68; cs_n held low past wr_n rise
`include "bim_cfg.svh"
module tb_bim_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rstn = 0, cs_n = 1, rd_n = 1, wr_n = 1;
  logic sonet_mode = 0, stm1_mode = 0, sdh_struct_valid = 0;
  logic drop_frame_start = 0, drop_v1_mark = 0, add_frame_start = 0, add_v1_mark = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] data_in = 8'h00, blk_status_high = 8'h00, blk_status_low = 8'h00;
  logic [7:0] drop_data_in = 8'h00, data_out, drop_data, d;
  logic data_oe, irq_n, jitter_atten_quick_lock_off, map_select, drop_data_oe;
  logic drop_frame_marker, add_frame_marker, add_frame_marker_oe;
  logic [1:0] want;
  logic [15:0] offs [3] = '{`BIM_OFF_EN_HIGH, `BIM_OFF_EN_LOW, `BIM_OFF_MODE_LOW};
  logic [7:0] msks [3] = '{`BIM_MASK_HIGH, `BIM_MASK_LOW, `BIM_MASK_MODE};
  int ib [4] = '{2, 1, 6, 5};
  int n_errors = 0, check_count = 0;
  bim_top u_bim_top (
    .clock(clock),
    .rstn(rstn),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .addr(addr),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .blk_status_high(blk_status_high),
    .blk_status_low(blk_status_low),
    .irq_n(irq_n),
    .jitter_atten_quick_lock_off(jitter_atten_quick_lock_off),
    .map_select(map_select),
    .sonet_mode(sonet_mode),
    .stm1_mode(stm1_mode),
    .sdh_struct_valid(sdh_struct_valid),
    .drop_data_in(drop_data_in),
    .drop_data(drop_data),
    .drop_data_oe(drop_data_oe),
    .drop_frame_start(drop_frame_start),
    .drop_v1_mark(drop_v1_mark),
    .drop_frame_marker(drop_frame_marker),
    .add_frame_start(add_frame_start),
    .add_v1_mark(add_v1_mark),
    .add_frame_marker(add_frame_marker),
    .add_frame_marker_oe(add_frame_marker_oe)
  );
  // Readback of a writable byte: unused bits read as zero
  function automatic logic [7:0] exp_byte(logic [7:0] v, logic [7:0] m);
    return v & m;
  endfunction
  // Marker: frame start, or V1 when enabled in STS-3/STM-1 mode
  function automatic logic [1:0] exp_mark(logic start, logic v1, logic en, logic stm1);
    return {2{start || (v1 && en && stm1)}};
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(logic [8:0] seen, logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] v);
    cs_n = 0;
    addr = a;
    data_in = v;
    wr_n = 0;
    step(3);
    wr_n = 1;
    step(6);
    cs_n = 1;
    step(2);
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] v);
    cs_n = 0;
    addr = a;
    rd_n = 0;
    step(6);
    chk(data_out, v);
    chk(data_oe, 1'b1);
    rd_n = 1;
    cs_n = 1;
    step(6);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    d = 8'($urandom(68));
    step(6);
    rstn = 1;
    step(4);
    for (int i = 0; i < 3; i++) rd(offs[i], 8'h00);
    rd(16'h0118, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr(offs[i % 3], d);
      rd(offs[i % 3], exp_byte(d, msks[i % 3]));
    end
    $display("test regs done");
    for (int k = 0; k < 4; k++) begin
      d = 8'h01 << ib[k];
      wr(offs[k / 2], msks[k / 2] & ~d);
      if (k < 2) blk_status_high = d;
      else blk_status_low = d;
      step(3);
      chk(irq_n, 1'b1);
      rd(k < 2 ? `BIM_OFF_ST_HIGH : `BIM_OFF_ST_LOW, d);
      wr(offs[k / 2], d);
      chk(irq_n, 1'b0);
      blk_status_high = 8'h00;
      blk_status_low = 8'h00;
      step(3);
      chk(irq_n, 1'b1);
    end
    $display("test irq done");
    wr(offs[2], 8'h91);
    chk({add_frame_marker_oe, map_select, jitter_atten_quick_lock_off}, 3'b111);
    wr(offs[2], 8'h00);
    chk(jitter_atten_quick_lock_off, 1'b0);
    drop_data_in = 8'($urandom);
    sdh_struct_valid = 1;
    step(3);
    chk({drop_data_oe, drop_data}, 9'h000);
    sdh_struct_valid = 0;
    wr(offs[2], 8'h40);
    chk(drop_data_oe, 1'b0);
    sdh_struct_valid = 1;
    step(3);
    chk({drop_data_oe, drop_data}, {1'b1, drop_data_in});
    sdh_struct_valid = 0;
    step(2);
    chk(drop_data_oe, 1'b0);
    sonet_mode = 1;
    wr(offs[2], 8'h00);
    chk(drop_data_oe, 1'b1);
    sonet_mode = 0;
    $display("test drop done");
    // Marker pulses are one cycle wide, so sample right after the edge
    for (int j = 0; j < 4; j++) begin
      stm1_mode = (j != 1);
      wr(offs[2], j == 2 ? 8'h00 : 8'h20);
      drop_v1_mark = (j < 3);
      add_v1_mark = (j < 3);
      drop_frame_start = (j == 3);
      add_frame_start = (j == 3);
      step(1);
      {drop_v1_mark, add_v1_mark, drop_frame_start, add_frame_start} = 4'h0;
      want = exp_mark(j == 3, j < 3, j != 2, j != 1);
      chk({drop_frame_marker, add_frame_marker}, want);
    end
    $display("test marker done");
    rstn = 0;
    step(4);
    rstn = 1;
    step(2);
    rd(offs[2], 8'h00);
    $display("test reset done");
    tally_and_finish;
  end
endmodule // tb_bim_top
